// ===== src/debug_control.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "debug_control_defines.svh"

// How it works
// - halt bit one stops core instruction fetch
// - clearing halt bit lets core resume
// - armed breakpoint opcode sets halt bit itself
// - read-protect blocks clearing halt; reset only
// - unarmed breakpoint opcode runs as no-op
// - ack enabled sends FFH per armed breakpoint; a hit while one is pending merges
// - writing reset bit starts device reset
// - requested reset leaves debug state intact
// - reset bit self-clears when sequence ends
module debug_control
    import debug_control_pkg::*;
#(
    parameter int RESET_CYCLES = `DBG_RESET_CYCLES
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`DBG_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`DBG_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   opcode_decode,
    input  wire logic [7:0]             opcode_byte,
    input  wire logic                   read_protect,
    output logic                        fetch_halt,
    output logic                        break_nop,
    output logic                        break_taken,
    output logic                        device_reset,
    output logic [7:0]                  ack_data,
    output logic                        ack_valid,
    input  wire logic                   ack_ready
);

    localparam int CNT_W = $clog2(RESET_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESET_CYCLES - 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic                   debug_halt_flag;
    logic                   breakpoint_arm;
    logic                   halt_ack_enable;
    reset_seq_t             seq;
    logic [CNT_W-1:0]       seq_cnt;

    logic                   aw_full;
    logic                   w_full;
    logic [`DBG_ADDR_W-1:0] aw_addr;
    logic [7:0]             w_byte;
    logic                   w_lane0;

    // ----------------------------------------------------------------
    // write channel decode
    // ----------------------------------------------------------------
    wire aw_take      = s_axi_awvalid & s_axi_awready;
    wire w_take       = s_axi_wvalid & s_axi_wready;
    wire do_write     = aw_full & w_full & ~s_axi_bvalid;
    wire wr_is_ctl    = (aw_addr == `DBG_CTL_OFFSET);
    wire wr_is_stat   = (aw_addr == `DBG_STAT_OFFSET);
    wire wr_mapped    = wr_is_ctl | wr_is_stat;
    wire ctl_write    = do_write & wr_is_ctl & w_lane0;
    wire next_aw_full = (aw_full | aw_take) & ~do_write;
    wire next_w_full  = (w_full | w_take) & ~do_write;
    wire next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);

    // ----------------------------------------------------------------
    // read channel decode
    // ----------------------------------------------------------------
    wire ar_take      = s_axi_arvalid & s_axi_arready;
    wire rd_is_ctl    = (s_axi_araddr == `DBG_CTL_OFFSET);
    wire rd_is_stat   = (s_axi_araddr == `DBG_STAT_OFFSET);
    wire next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // ----------------------------------------------------------------
    // register images
    // ----------------------------------------------------------------
    wire reset_busy = (seq == SEQ_BUSY);

    // middle bits are tied low in the image
    wire [7:0] ctl_image = {debug_halt_flag,
                            breakpoint_arm,
                            halt_ack_enable,
                            4'h0,
                            reset_busy};

    wire [7:0] stat_image = {5'h00, ack_valid, read_protect, reset_busy};

    wire [31:0] rd_word = rd_is_ctl  ? {24'h000000, ctl_image} :
                          rd_is_stat ? {24'h000000, stat_image} :
                                       32'h00000000;
    wire [1:0]  rd_resp = (rd_is_ctl | rd_is_stat) ? `DBG_RESP_OKAY
                                                   : `DBG_RESP_SLVERR;

    // ----------------------------------------------------------------
    // breakpoint decode
    // ----------------------------------------------------------------
    // the core is held in reset during the sequence, so its decode is ignored
    wire bp_hit   = opcode_decode & (opcode_byte == `DBG_BRK_OPCODE) & ~reset_busy;
    wire bp_set   = bp_hit & breakpoint_arm;
    wire bp_nop   = bp_hit & ~breakpoint_arm;

    // ----------------------------------------------------------------
    // next values of the control fields
    // ----------------------------------------------------------------
    // fields come from the captured byte: wdata may move once W is taken
    wire new_halt = w_byte[`DBG_HALT_BIT];
    // a zero is dropped while the flash is read-protected
    wire halt_wr  = ctl_write & (new_halt | ~read_protect);

    // an armed breakpoint beats a clearing write in the same cycle
    wire next_debug_halt_flag = bp_set  ? 1'b1 :
                                halt_wr ? new_halt :
                                          debug_halt_flag;

    wire next_breakpoint_arm  = ctl_write ? w_byte[`DBG_ARM_BIT]
                                          : breakpoint_arm;
    wire next_halt_ack_enable = ctl_write ? w_byte[`DBG_ACK_BIT]
                                          : halt_ack_enable;

    // ----------------------------------------------------------------
    // device reset sequence
    // ----------------------------------------------------------------
    wire seq_start = ctl_write & w_byte[`DBG_RST_BIT] & ~reset_busy;
    wire seq_done  = reset_busy & (seq_cnt == CNT_LAST);

    reset_seq_t next_seq;
    always_comb begin
        next_seq = seq;
        unique case (seq)
            SEQ_IDLE: begin
                if (seq_start) begin
                    next_seq = SEQ_BUSY;
                end
            end
            SEQ_BUSY: begin
                if (seq_done) begin
                    next_seq = SEQ_IDLE;
                end
            end
            default: begin
                next_seq = SEQ_IDLE;
            end
        endcase
    end

    wire [CNT_W-1:0] next_seq_cnt = reset_busy ? seq_cnt + CNT_W'(1) : '0;

    // ----------------------------------------------------------------
    // acknowledge byte toward the host link
    // ----------------------------------------------------------------
    // a second breakpoint while a byte is pending merges into it
    wire ack_fire       = bp_set & halt_ack_enable;
    wire next_ack_valid = ack_fire | (ack_valid & ~ack_ready);

    // ----------------------------------------------------------------
    // debug unit flops: only aresetn clears them, never device_reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_halt_flag <= 1'b0;
            breakpoint_arm  <= 1'b0;
            halt_ack_enable <= 1'b0;
            seq             <= SEQ_IDLE;
            seq_cnt         <= '0;
        end else begin
            debug_halt_flag <= next_debug_halt_flag;
            breakpoint_arm  <= next_breakpoint_arm;
            halt_ack_enable <= next_halt_ack_enable;
            seq             <= next_seq;
            seq_cnt         <= next_seq_cnt;
        end
    end

    // ----------------------------------------------------------------
    // core- and host-facing outputs
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            break_nop    <= 1'b0;
            break_taken  <= 1'b0;
            device_reset <= 1'b0;
            ack_valid    <= 1'b0;
            ack_data     <= 8'h00;
        end else begin
            break_nop    <= bp_nop;
            break_taken  <= bp_set;
            device_reset <= (next_seq == SEQ_BUSY);
            ack_valid    <= next_ack_valid;
            ack_data     <= `DBG_ACK_BYTE;
        end
    end

    // halt flag is itself a flop
    assign fetch_halt = debug_halt_flag;

    // ----------------------------------------------------------------
    // axi write path
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_byte        <= 8'h00;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DBG_RESP_OKAY;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= ~next_aw_full;
            s_axi_wready  <= ~next_w_full;
            s_axi_bvalid  <= next_bvalid;
            if (aw_take) begin
                aw_addr <= {s_axi_awaddr[`DBG_ADDR_W-1:2], 2'b00};
            end
            if (w_take) begin
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bresp <= wr_mapped ? `DBG_RESP_OKAY : `DBG_RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi read path
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DBG_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_resp;
            end
        end
    end

endmodule // debug_control

`default_nettype wire

// ===== src/debug_control_defines.svh
`ifndef DEBUG_CONTROL_DEFINES_SVH
`define DEBUG_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DBG_ADDR_W          8
`define DBG_CTL_OFFSET      8'h00
`define DBG_STAT_OFFSET     8'h04

// ----------------------------------------------------------------
// debug_control fields
// ----------------------------------------------------------------
`define DBG_CTL_RESET       8'h00
`define DBG_HALT_BIT        7
`define DBG_ARM_BIT         6
`define DBG_ACK_BIT         5
`define DBG_RST_BIT         0

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define DBG_STAT_BUSY_BIT   0
`define DBG_STAT_PROT_BIT   1
`define DBG_STAT_ACKP_BIT   2

// ----------------------------------------------------------------
// codes and counts
// ----------------------------------------------------------------
`define DBG_BRK_OPCODE      8'h00
`define DBG_ACK_BYTE        8'hFF
`define DBG_RESP_OKAY       2'h0
`define DBG_RESP_SLVERR     2'h2
`define DBG_RESET_CYCLES    16

`endif

// ===== src/debug_control_pkg.sv
package debug_control_pkg;

    typedef logic [7:0] byte_t;

    // one-hot progress of a software-requested device reset
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } reset_seq_t;

endpackage

// ===== sim/debug_control_chk.sv
`timescale 1ns/1ps
`default_nettype none

module debug_control_chk #(
    parameter int RESET_CYCLES = 16
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       opcode_decode,
    input wire logic [7:0] opcode_byte,
    input wire logic       read_protect,
    input wire logic       fetch_halt,
    input wire logic       break_nop,
    input wire logic       break_taken,
    input wire logic       device_reset,
    input wire logic [7:0] ack_data,
    input wire logic       ack_valid,
    input wire logic       ack_ready
);
    int         busy_cnt;
    wire logic  brk_seen = opcode_decode && (opcode_byte == 8'h00);

    // ------
    // length of the requested reset pulse
    // ------
    always_ff @(posedge aclk) begin
        busy_cnt <= (!aresetn || !device_reset) ? 0 : busy_cnt + 1;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    break_cause_a: assert property (break_taken |-> $past(brk_seen))
        else $error("break pulse without breakpoint opcode");
    break_halt_a: assert property (break_taken |-> fetch_halt)
        else $error("break taken but fetch not halted");
    nop_cause_a: assert property (break_nop |-> $past(brk_seen) && !break_taken)
        else $error("bad no-operation pulse");
    ack_byte_a: assert property (ack_valid |-> ack_data == 8'hFF)
        else $error("acknowledge byte wrong");
    ack_rise_a: assert property ($rose(ack_valid) |-> break_taken)
        else $error("acknowledge without breakpoint");
    ack_hold_a: assert property (ack_valid && !ack_ready |=> ack_valid)
        else $error("acknowledge dropped before taken");
    halt_lock_a: assert property (read_protect && fetch_halt |=> fetch_halt)
        else $error("halt cleared under read protect");
    reset_len_a: assert property ($fell(device_reset) |-> busy_cnt == RESET_CYCLES)
        else $error("requested reset length wrong");
endmodule // debug_control_chk

bind debug_control debug_control_chk #(.RESET_CYCLES(RESET_CYCLES)) chk (.aclk, .aresetn,
    .opcode_decode, .opcode_byte, .read_protect, .fetch_halt, .break_nop, .break_taken,
    .device_reset, .ack_data, .ack_valid, .ack_ready);

`default_nettype wire

// ===== sim/debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module debug_host_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    input  wire logic [7:0] ack_data,
    input  wire logic       ack_valid,
    output logic            ack_ready,
    output int              bytes,
    output logic [7:0]      last
);
    int wait_cnt;

    // ------
    // slow mode keeps the device holding its byte
    // ------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_ready <= 1'b0;
            bytes <= 0;
            wait_cnt <= 0;
            last <= 8'h00;
        end else if (ack_valid && ack_ready) begin
            ack_ready <= 1'b0;
            bytes <= bytes + 1;
            last <= ack_data;
            wait_cnt <= 0;
        end else if (ack_valid) begin
            ack_ready <= slow ? (wait_cnt >= 3) : 1'b1;
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule // debug_host_model

`default_nettype wire

// ===== sim/debug_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module debug_control_tb;
    localparam int RC = 4;
    logic        aclk = 0, aresetn = 0, dec = 0, prot = 0, slow = 1;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, opb = 0;
    logic [31:0] wdata = 0, rv;
    logic [3:0]  wstrb = 0;
    logic [1:0]  resp;
    wire logic   awready, wready, bvalid, arready, rvalid, halt, nop, taken, drst, ackv, ackr;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  ackd, last;
    int          bytes, nt = 0, nn = 0, mismatches = 0, checks = 0;

    debug_control #(.RESET_CYCLES(RC)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .opcode_decode(dec), .opcode_byte(opb), .read_protect(prot), .fetch_halt(halt),
        .break_nop(nop), .break_taken(taken), .device_reset(drst), .ack_data(ackd),
        .ack_valid(ackv), .ack_ready(ackr));
    debug_host_model host (.aclk(aclk), .aresetn(aresetn), .slow(slow), .ack_data(ackd),
        .ack_valid(ackv), .ack_ready(ackr), .bytes(bytes), .last(last));

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        if (taken === 1'b1) nt++;
        if (nop === 1'b1) nn++;
    end

    // ------
    // bus and core tasks
    // ------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // each valid drops once taken; the response is awaited with bready high
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task breakpoint_opcode(input logic [7:0] b);
        @(posedge aclk);
        dec <= 1'b1;
        opb <= b;
        @(posedge aclk);
        dec <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        chk(rv, 32'h0);
        rd(8'h08);
        chk(resp, 32'h2);
        wr(8'h00, 32'hFFFF_FFFE);
        chk(resp, 32'h0);
        rd(8'h00);
        chk(rv, 32'hE0);
        chk(halt, 32'h1);
        wr(8'h00, 32'h0);
        chk(halt, 32'h0);
        wr(8'h00, 32'h60);
        breakpoint_opcode(8'h00);
        chk(nt, 32'h1);
        chk(halt, 32'h1);
        chk(bytes, 32'h1);
        chk(last, 32'hFF);
        breakpoint_opcode(8'h3A);
        chk(nt, 32'h1);
        slow <= 1'b0;
        wr(8'h00, 32'h60);
        breakpoint_opcode(8'h00);
        chk(bytes, 32'h2);
        wr(8'h00, 32'h40);
        chk(halt, 32'h0);
        breakpoint_opcode(8'h00);
        chk(bytes, 32'h2);
        wr(8'h00, 32'h0);
        breakpoint_opcode(8'h00);
        chk(nn, 32'h1);
        chk(halt, 32'h0);
        prot <= 1'b1;
        wr(8'h00, 32'h81);
        chk(drst, 32'h1);
        rd(8'h00);
        chk(rv, 32'h81);
        repeat (RC + 2) @(posedge aclk);
        chk(drst, 32'h0);
        chk(halt, 32'h1);
        wr(8'h00, 32'h0);
        rd(8'h00);
        chk(rv, 32'h80);
        prot <= 1'b0;
        wr(8'h00, 32'h41);
        repeat (RC + 2) @(posedge aclk);
        rd(8'h00);
        chk(rv, 32'h40);
        wr(8'h00, 32'h80);
        prot <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(halt, 32'h0);
        finish_test();
    end
endmodule // debug_control_tb

`default_nettype wire
